//--- dv/dap_far_mem.sv
`timescale 1ns/1ps

// ************
// Far-side memory for one port; slow mode withholds the readies
// ************
module dap_far_mem
    import dap_pkg::*;
(
    // Clock, reset and pacing
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_en,
    input wire logic slow,
    // Read side
    input wire logic arvalid,
    input wire dap_ar_t ar,
    output logic arready,
    output logic rvalid,
    output dap_r_t r,
    input wire logic rready,
    // Write side
    input wire logic awvalid,
    input wire dap_aw_t aw,
    output logic awready,
    input wire logic wvalid,
    input wire dap_w_t w,
    output logic wready,
    output logic bvalid,
    output dap_b_t b,
    input wire logic bready
);
    logic [1:0] tick_reg;
    logic rbusy_reg;
    logic [3:0] rlen_reg;
    logic aw_seen_reg;
    logic w_done_reg;
    logic [3:0] awid_reg;

    // Free-running pacing count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= 2'h0;
        end else begin
            tick_reg <= tick_reg + 2'h1;
        end
    end
    assign arready = !rbusy_reg && (!slow || tick_reg[0]);
    assign awready = !aw_seen_reg && (!slow || tick_reg[1]);
    assign wready = !w_done_reg && (!slow || !tick_reg[0]);

    // Read beats carry address and beat number; released payload is inverted
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rbusy_reg <= 1'b0;
            rlen_reg <= 4'h0;
            rvalid <= 1'b0;
            r <= '0;
        end else if (bus_en && arvalid && arready) begin
            rbusy_reg <= 1'b1;
            rlen_reg <= ar.len;
            rvalid <= 1'b1;
            r <= '{ar.id, {ar.addr, 28'h0, 4'h0}, 2'h0, ar.len == 4'h0};
        end else if (bus_en && rvalid && rready) begin
            rbusy_reg <= !r.last;
            rvalid <= !r.last;
            r <= r.last ? ~r : '{r.id, r.data + 64'h1, 2'h0, r.data[3:0] + 4'h1 == rlen_reg};
        end
    end

    // Respond once address and last beat are in
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_seen_reg <= 1'b0;
            w_done_reg <= 1'b0;
            awid_reg <= 4'h0;
            bvalid <= 1'b0;
            b <= '0;
        end else if (bus_en) begin
            if (awvalid && awready) begin
                aw_seen_reg <= 1'b1;
                awid_reg <= aw.id;
            end
            if (wvalid && wready && w.last) begin
                w_done_reg <= 1'b1;
            end
            if (aw_seen_reg && w_done_reg && !bvalid) begin
                bvalid <= 1'b1;
                b <= '{awid_reg, 2'h0};
                aw_seen_reg <= 1'b0;
                w_done_reg <= 1'b0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                b <= ~b;
            end
        end
    end
endmodule : dap_far_mem

//--- dv/dap_props.sv
`timescale 1ns/1ps
`include "dap_consts.svh"

// ************
// Port checks
// ************
module dap_props
    import dap_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Controls and requests
    input wire logic bus_domain_clock_enable,
    input wire logic second_port_enable,
    input wire logic [`DAP_NPORT-1:0] cmd_valid,
    input wire dap_cmd_t [`DAP_NPORT-1:0] cmd,
    input wire logic [`DAP_NPORT-1:0] cmd_ready,
    // Bus side
    input wire logic [`DAP_NPORT-1:0] m_arvalid,
    input wire dap_ar_t [`DAP_NPORT-1:0] m_ar,
    input wire logic [`DAP_NPORT-1:0] m_arready,
    input wire logic [`DAP_NPORT-1:0] m_awvalid,
    input wire dap_aw_t [`DAP_NPORT-1:0] m_aw,
    input wire logic [`DAP_NPORT-1:0] m_wvalid,
    input wire dap_w_t [`DAP_NPORT-1:0] m_w,
    input wire logic [`DAP_NPORT-1:0] m_wready,
    input wire logic [`DAP_NPORT-1:0] m_rready,
    input wire logic [`DAP_NPORT-1:0] m_bready
);
    logic en;
    logic [3:0] wid_reg;
    logic [3:0] wlen_reg;
    logic [3:0] wbeat_reg;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    assign en = bus_domain_clock_enable;

    // Port 0 write in flight: id, clipped length, beats so far
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wid_reg <= 4'h0;
            wlen_reg <= 4'h0;
            wbeat_reg <= 4'h0;
        end else if (cmd_valid[0] && cmd_ready[0] && cmd[0].write) begin
            wid_reg <= cmd[0].id;
            wlen_reg <= (cmd[0].len > 4'h3) ? 4'h3 : cmd[0].len;
            wbeat_reg <= 4'h0;
        end else if (m_wvalid[0] && m_wready[0] && en) begin
            wbeat_reg <= wbeat_reg + 4'h1;
        end
    end

    sequence s_rd_take;
        cmd_valid[0] && cmd_ready[0] && !cmd[0].write;
    endsequence
    sequence s_wr_take;
        cmd_valid[0] && cmd_ready[0] && cmd[0].write;
    endsequence

    chk_rd_shape: assert property (m_arvalid[0] |-> m_ar[0].len <= 4'h3
        && m_ar[0].lock != 2'h3 && m_ar[0].burst inside {2'h1, 2'h2}) else $error("read code");
    chk_wr_shape: assert property (m_awvalid[0] |-> m_aw[0].len <= 4'h3
        && !m_aw[0].lock[1] && m_aw[0].burst inside {2'h1, 2'h2}) else $error("write code");
    chk_size_kept: assert property (s_rd_take |=> m_ar[0].size == $past(cmd[0].size))
        else $error("ar size");
    chk_ar_user: assert property (s_rd_take |=> m_arvalid[0]
        && m_ar[0].user == $past({cmd[0].attr, cmd[0].shared})) else $error("ar user");
    chk_aw_user: assert property (s_wr_take |=> m_awvalid[0] && m_aw[0].user ==
        $past({cmd[0].clean_evict, cmd[0].evict, cmd[0].attr, cmd[0].shared}))
        else $error("aw user");
    chk_port1_user: assert property (cmd_valid[1] && cmd_ready[1] && !cmd[1].write
        |=> m_arvalid[1] && m_ar[1].user == $past({cmd[1].attr, cmd[1].shared}))
        else $error("port 1 ar user");
    chk_port1_off: assert property (!second_port_enable [*2] |-> !cmd_ready[1])
        else $error("port 1 taken off");
    chk_ar_hold: assert property (m_arvalid[0] && !(m_arready[0] && en)
        |=> m_arvalid[0] && $stable(m_ar[0])) else $error("ar not held");
    chk_w_hold: assert property (m_wvalid[0] && !(m_wready[0] && en)
        |=> m_wvalid[0] && $stable(m_w[0])) else $error("w not held");
    chk_w_last: assert property (m_wvalid[0] |-> m_w[0].last == (wbeat_reg == wlen_reg))
        else $error("last misplaced");
    chk_w_id: assert property (m_wvalid[0] |-> m_w[0].id == wid_reg)
        else $error("w id differs");
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |->
        (m_arvalid | m_awvalid | m_wvalid | m_rready | m_bready | cmd_ready) == 2'h0)
        else $error("active in reset");
endmodule : dap_props

bind dap_top dap_props u_props (.*);

//--- dv/test_dual_axi_master_port.sv
`timescale 1ns/1ps
`include "dap_consts.svh"
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module test_dual_axi_master_port
    import dap_pkg::*;
;
    typedef struct packed {
        dap_cmd_t c;
        logic [3:0] xlen;
        logic [1:0] xburst;
        logic [1:0] xlock;
    } dap_row_t;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b1;
    logic bus_en = 1'b1;
    logic port_one_on = 1'b1;
    logic slow = 1'b0;
    logic seen;
    logic [1:0] cmd_valid = '0, wd_valid = '0, rd_ready = '1, rsp_ready = '1;
    logic [1:0] cmd_ready, wd_ready, rd_valid, rsp_valid;
    logic [1:0] m_arvalid, m_arready, m_awvalid, m_awready, m_wvalid, m_wready;
    logic [1:0] m_rvalid, m_rready, m_bvalid, m_bready;
    dap_cmd_t [1:0] cmd = '0;
    dap_wd_t [1:0] wd = '0;
    dap_r_t [1:0] rd, m_r;
    dap_b_t [1:0] rsp, m_b;
    dap_ar_t [1:0] m_ar;
    dap_aw_t [1:0] m_aw;
    dap_w_t [1:0] m_w;
    dap_ar_t ar_q;
    dap_aw_t aw_q;
    dap_w_t w_q;
    dap_r_t rd_q;
    dap_b_t rsp_q;
    dap_row_t rows[10];
    int cnt[3];
    int pn = 0;
    int cyc = 0;
    int errors = 0;
    int cmp_count = 0;

    always #10 ref_clk = ~ref_clk;

    dap_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_domain_clock_enable(bus_en),
        .second_port_enable(port_one_on), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .wd_valid(wd_valid), .wd(wd), .wd_ready(wd_ready),
        .rd_valid(rd_valid), .rd(rd), .rd_ready(rd_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .rsp_ready(rsp_ready), .m_arvalid(m_arvalid), .m_ar(m_ar),
        .m_arready(m_arready), .m_awvalid(m_awvalid), .m_aw(m_aw), .m_awready(m_awready),
        .m_wvalid(m_wvalid), .m_w(m_w), .m_wready(m_wready), .m_rvalid(m_rvalid),
        .m_r(m_r), .m_rready(m_rready), .m_bvalid(m_bvalid), .m_b(m_b), .m_bready(m_bready));

    for (genvar g = 0; g < 2; g++) begin : g_far
        dap_far_mem u_far (.ref_clk(ref_clk), .rst_n(rst_n), .bus_en(bus_en), .slow(slow),
            .arvalid(m_arvalid[g]), .ar(m_ar[g]), .arready(m_arready[g]), .rvalid(m_rvalid[g]),
            .r(m_r[g]), .rready(m_rready[g]), .awvalid(m_awvalid[g]), .aw(m_aw[g]),
            .awready(m_awready[g]), .wvalid(m_wvalid[g]), .w(m_w[g]), .wready(m_wready[g]),
            .bvalid(m_bvalid[g]), .b(m_b[g]), .bready(m_bready[g]));
    end

    // Bus pacing and hang limit
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        bus_en <= !slow || cyc % 3 == 0;
        rd_ready <= {2{!slow || cyc[0]}};
        rsp_ready <= {2{!slow || cyc[1]}};
        if (cyc == 30000) begin
            errors++;
            close_out();
        end
    end

    // Handshakes seen on the port under test
    always @(posedge ref_clk) begin
        if (m_arvalid[pn] && m_arready[pn] && bus_en) ar_q = m_ar[pn];
        if (m_awvalid[pn] && m_awready[pn] && bus_en) aw_q = m_aw[pn];
        if (m_wvalid[pn] && m_wready[pn] && bus_en) begin
            w_q = m_w[pn];
            cnt[0]++;
        end
        if (rd_valid[pn] && rd_ready[pn]) begin
            rd_q = rd[pn];
            cnt[1]++;
        end
        if (rsp_valid[pn] && rsp_ready[pn]) begin
            rsp_q = rsp[pn];
            cnt[2]++;
        end
    end

    function automatic dap_row_t mk(logic w, logic [3:0] ln, logic [1:0] sz, logic [1:0] bu,
        logic [1:0] lk, logic [3:0] xl, logic [1:0] xb, logic [1:0] xk);
        mk.c = '{w, {16'h8000, ln, 2'h0, sz, bu, lk, 4'h0}, ln, sz, bu, lk, 4'h3, 3'h2,
            {sz, lk}, {bu, ln[1:0]}, ln[0], sz[0], sz[1]};
        mk.xlen = xl;
        mk.xburst = xb;
        mk.xlock = xk;
    endfunction : mk

    // Hold request until ready at a rising edge
    task wait_rdy(input logic wr);
        int t;
        t = 0;
        @(negedge ref_clk);
        while (!(wr ? wd_ready[pn] : cmd_ready[pn]) && t < 500) begin
            @(negedge ref_clk);
            t++;
        end
        @(posedge ref_clk);
    endtask : wait_rdy

    task run(input dap_row_t r);
        int n;
        logic [52:0] hd;
        n = int'(r.xlen) + 1;
        hd = {r.c.addr, r.xlen, r.c.size, r.xburst, r.xlock, r.c.cache, r.c.prot, r.c.id};
        cnt = '{default: 0};
        @(posedge ref_clk);
        cmd_valid[pn] <= 1'b1;
        cmd[pn] <= r.c;
        wait_rdy(1'b0);
        cmd_valid[pn] <= 1'b0;
        for (int i = 0; i < n && r.c.write; i++) begin
            wd_valid[pn] <= 1'b1;
            wd[pn] <= '{{r.c.addr, 28'h0, 4'(i)}, 8'hff >> i};
            wait_rdy(1'b1);
        end
        wd_valid[pn] <= 1'b0;
        for (int t = 0; t < 600 && cnt[r.c.write ? 2 : 1] < (r.c.write ? 1 : n); t++)
            @(negedge ref_clk);
        if (r.c.write) begin
            `CMP(aw_q, ({hd, r.c.clean_evict, r.c.evict, r.c.attr, r.c.shared}))
            `CMP(cnt[0], n)
            `CMP(w_q, ({r.c.id, r.c.addr, 28'h0, 4'(n - 1), 8'hff >> (n - 1), 1'b1}))
            `CMP(rsp_q.id, r.c.id)
        end else begin
            `CMP(ar_q, ({hd, r.c.attr, r.c.shared}))
            `CMP(cnt[1], n)
            `CMP(rd_q, ({r.c.id, r.c.addr, 28'h0, 4'(n - 1), 2'h0, 1'b1}))
        end
    endtask : run

    task close_out;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        rst_n <= 1'b0; // A real edge at time 0
        rows[0] = mk(1'b0, 4'h0, 2'h0, 2'h1, 2'h0, 4'h0, 2'h1, 2'h0);
        rows[1] = mk(1'b0, 4'h1, 2'h1, 2'h2, 2'h1, 4'h1, 2'h2, 2'h1);
        rows[2] = mk(1'b0, 4'h2, 2'h2, 2'h0, 2'h2, 4'h2, 2'h1, 2'h2);
        rows[3] = mk(1'b0, 4'h3, 2'h3, 2'h3, 2'h3, 4'h3, 2'h1, 2'h0);
        rows[4] = mk(1'b0, 4'h5, 2'h1, 2'h2, 2'h0, 4'h3, 2'h2, 2'h0);
        rows[5] = mk(1'b1, 4'h0, 2'h3, 2'h1, 2'h0, 4'h0, 2'h1, 2'h0);
        rows[6] = mk(1'b1, 4'h1, 2'h2, 2'h2, 2'h1, 4'h1, 2'h2, 2'h1);
        rows[7] = mk(1'b1, 4'h3, 2'h1, 2'h1, 2'h2, 4'h3, 2'h1, 2'h0);
        rows[8] = mk(1'b1, 4'hf, 2'h0, 2'h2, 2'h3, 4'h3, 2'h2, 2'h0);
        rows[9] = mk(1'b1, 4'h2, 2'h3, 2'h0, 2'h1, 4'h2, 2'h1, 2'h1);
        repeat (4) @(negedge ref_clk);
        `CMP({m_arvalid, m_awvalid, m_wvalid, m_rready, m_bready, cmd_ready}, 12'h0)
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CMP({cmd_ready, m_rready, m_bready}, 6'h3f)
        foreach (rows[i]) run(rows[i]);
        pn = 1;
        run(rows[3]);
        run(rows[8]);
        // Port 1 off: a held request stays untaken
        @(posedge ref_clk);
        port_one_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cmd_valid[1] <= 1'b1;
        seen = 1'b0;
        repeat (12) begin
            @(negedge ref_clk);
            seen = seen | cmd_ready[1] | m_awvalid[1];
        end
        `CMP(seen, 1'b0)
        @(posedge ref_clk);
        cmd_valid[1] <= 1'b0;
        @(posedge ref_clk);
        port_one_on <= 1'b1;
        slow <= 1'b1;
        pn = 0;
        run(rows[4]);
        run(rows[8]);
        close_out();
    end
endmodule : test_dual_axi_master_port

//--- hdl/dap_consts.svh
`ifndef DAP_CONSTS_SVH
`define DAP_CONSTS_SVH

// ****************************************************************
// Bus widths and port count
// ****************************************************************
`define DAP_ADDR_W 32
`define DAP_DATA_W 64
`define DAP_STRB_W 8
`define DAP_ID_W 4
`define DAP_NPORT 2

// ****************************************************************
// Burst length, size, type and lock encodings
// ****************************************************************
`define DAP_LEN_ONE 4'h0
`define DAP_LEN_MAX 4'h3
`define DAP_SIZE_8 2'h0
`define DAP_SIZE_16 2'h1
`define DAP_SIZE_32 2'h2
`define DAP_SIZE_64 2'h3
`define DAP_BURST_INCR 2'h1
`define DAP_BURST_WRAP 2'h2
`define DAP_LOCK_NORMAL 2'h0
`define DAP_LOCK_EXCL 2'h1
`define DAP_LOCK_LOCKED 2'h2

// ****************************************************************
// User sideband bit positions
// ****************************************************************
`define DAP_USER_SHARED 0
`define DAP_USER_ATTR_LO 1
`define DAP_USER_ATTR_HI 4
`define DAP_AWUSER_EVICT 5
`define DAP_AWUSER_CLEAN 6

`endif

//--- hdl/dap_pkg.sv
`include "dap_consts.svh"

package dap_pkg;

    // ****************************************************************
    // Internal request and data carriers
    // ****************************************************************
    typedef struct packed {
        logic write;
        logic [`DAP_ADDR_W-1:0] addr;
        logic [3:0] len;
        logic [1:0] size;
        logic [1:0] burst;
        logic [1:0] lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [`DAP_ID_W-1:0] id;
        logic [3:0] attr;
        logic shared;
        logic evict;
        logic clean_evict;
    } dap_cmd_t;

    typedef struct packed {
        logic [`DAP_DATA_W-1:0] data;
        logic [`DAP_STRB_W-1:0] strb;
    } dap_wd_t;

    // ****************************************************************
    // Bus channel payloads
    // ****************************************************************
    typedef struct packed {
        logic [`DAP_ADDR_W-1:0] addr;
        logic [3:0] len;
        logic [1:0] size;
        logic [1:0] burst;
        logic [1:0] lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [`DAP_ID_W-1:0] id;
        logic [4:0] user;
    } dap_ar_t;

    typedef struct packed {
        logic [`DAP_ADDR_W-1:0] addr;
        logic [3:0] len;
        logic [1:0] size;
        logic [1:0] burst;
        logic [1:0] lock;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [`DAP_ID_W-1:0] id;
        logic [6:0] user;
    } dap_aw_t;

    typedef struct packed {
        logic [`DAP_ID_W-1:0] id;
        logic [`DAP_DATA_W-1:0] data;
        logic [`DAP_STRB_W-1:0] strb;
        logic last;
    } dap_w_t;

    typedef struct packed {
        logic [`DAP_ID_W-1:0] id;
        logic [`DAP_DATA_W-1:0] data;
        logic [1:0] resp;
        logic last;
    } dap_r_t;

    typedef struct packed {
        logic [`DAP_ID_W-1:0] id;
        logic [1:0] resp;
    } dap_b_t;

endpackage : dap_pkg

//--- hdl/dap_sink_slot.sv
`timescale 1ns/1ps

// One-entry holding stage for a channel the port receives (read data,
// write response). The far side is gated by the bus clock enable; the
// local side runs at full rate.
module dap_sink_slot
    import dap_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bus_en,
    // Far side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Local side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    logic in_ready_reg;
    logic out_valid_reg;
    logic out_valid_next;
    logic [W-1:0] out_data_reg;
    logic take;

    // Only an enabled edge completes a far-side transfer
    assign take = in_valid & in_ready_reg & bus_en;

    // ****************************************************************
    // Slot occupancy
    // ****************************************************************
    always_comb begin
        out_valid_next = out_valid_reg;
        if (take) begin
            out_valid_next = 1'b1;
        end else if (out_ready) begin
            out_valid_next = 1'b0;
        end
    end

    // Ready is registered, so it only offers a slot that is already free
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            in_ready_reg <= 1'b0;
        end else begin
            out_valid_reg <= out_valid_next;
            in_ready_reg <= ~out_valid_next;
        end
    end

    // Payload capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data_reg <= '0;
        end else if (take) begin
            out_data_reg <= in_data;
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

endmodule : dap_sink_slot

//--- hdl/dap_top.sv
`timescale 1ns/1ps
`include "dap_consts.svh"

module dap_top
    import dap_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Integration controls
    input wire logic bus_domain_clock_enable,
    input wire logic second_port_enable,
    // Internal requests, one per port
    input wire logic [`DAP_NPORT-1:0] cmd_valid,
    input wire dap_cmd_t [`DAP_NPORT-1:0] cmd,
    output logic [`DAP_NPORT-1:0] cmd_ready,
    // Internal write data
    input wire logic [`DAP_NPORT-1:0] wd_valid,
    input wire dap_wd_t [`DAP_NPORT-1:0] wd,
    output logic [`DAP_NPORT-1:0] wd_ready,
    // Internal read data
    output logic [`DAP_NPORT-1:0] rd_valid,
    output dap_r_t [`DAP_NPORT-1:0] rd,
    input wire logic [`DAP_NPORT-1:0] rd_ready,
    // Internal write responses
    output logic [`DAP_NPORT-1:0] rsp_valid,
    output dap_b_t [`DAP_NPORT-1:0] rsp,
    input wire logic [`DAP_NPORT-1:0] rsp_ready,
    // Read address channel
    output logic [`DAP_NPORT-1:0] m_arvalid,
    output dap_ar_t [`DAP_NPORT-1:0] m_ar,
    input wire logic [`DAP_NPORT-1:0] m_arready,
    // Write address channel
    output logic [`DAP_NPORT-1:0] m_awvalid,
    output dap_aw_t [`DAP_NPORT-1:0] m_aw,
    input wire logic [`DAP_NPORT-1:0] m_awready,
    // Write data channel
    output logic [`DAP_NPORT-1:0] m_wvalid,
    output dap_w_t [`DAP_NPORT-1:0] m_w,
    input wire logic [`DAP_NPORT-1:0] m_wready,
    // Read data channel
    input wire logic [`DAP_NPORT-1:0] m_rvalid,
    input wire dap_r_t [`DAP_NPORT-1:0] m_r,
    output logic [`DAP_NPORT-1:0] m_rready,
    // Write response channel
    input wire logic [`DAP_NPORT-1:0] m_bvalid,
    input wire dap_b_t [`DAP_NPORT-1:0] m_b,
    output logic [`DAP_NPORT-1:0] m_bready
);

    // ****************************************************************
    // Encoding helpers
    // ****************************************************************

    // Over-long requests are cut to four beats; the tail is the requester's job
    function automatic logic [3:0] clamp_len(input logic [3:0] len);
        clamp_len = (len > `DAP_LEN_MAX) ? `DAP_LEN_MAX : len;
    endfunction : clamp_len

    // Fixed and reserved types fall back to incrementing
    function automatic logic [1:0] fix_burst(input logic [1:0] burst);
        fix_burst = (burst == `DAP_BURST_WRAP) ? `DAP_BURST_WRAP : `DAP_BURST_INCR;
    endfunction : fix_burst

    function automatic dap_ar_t to_ar(input dap_cmd_t c);
        dap_ar_t a;
        a.addr = c.addr;
        a.len = clamp_len(c.len);
        a.size = c.size;
        a.burst = fix_burst(c.burst);
        // Reserved lock code 11 degrades to a normal access
        a.lock = (c.lock == `DAP_LOCK_LOCKED) ? `DAP_LOCK_LOCKED :
                 (c.lock == `DAP_LOCK_EXCL) ? `DAP_LOCK_EXCL : `DAP_LOCK_NORMAL;
        a.cache = c.cache;
        a.prot = c.prot;
        a.id = c.id;
        a.user = '0;
        a.user[`DAP_USER_ATTR_HI:`DAP_USER_ATTR_LO] = c.attr;
        a.user[`DAP_USER_SHARED] = c.shared;
        to_ar = a;
    endfunction : to_ar

    function automatic dap_aw_t to_aw(input dap_cmd_t c);
        dap_aw_t a;
        a.addr = c.addr;
        a.len = clamp_len(c.len);
        a.size = c.size;
        a.burst = fix_burst(c.burst);
        // Locked writes do not exist on this channel
        a.lock = (c.lock == `DAP_LOCK_EXCL) ? `DAP_LOCK_EXCL : `DAP_LOCK_NORMAL;
        a.cache = c.cache;
        a.prot = c.prot;
        a.id = c.id;
        a.user = '0;
        a.user[`DAP_AWUSER_CLEAN] = c.clean_evict;
        a.user[`DAP_AWUSER_EVICT] = c.evict;
        a.user[`DAP_USER_ATTR_HI:`DAP_USER_ATTR_LO] = c.attr;
        a.user[`DAP_USER_SHARED] = c.shared;
        to_aw = a;
    endfunction : to_aw

    // ****************************************************************
    // Per-port master engine
    // ****************************************************************
    genvar p;
    generate
        for (p = 0; p < `DAP_NPORT; p++) begin : g_port
            logic port_on;
            logic ar_v_reg;
            logic ar_v_next;
            dap_ar_t ar_reg;
            logic aw_v_reg;
            logic aw_v_next;
            dap_aw_t aw_reg;
            logic w_v_reg;
            logic w_v_next;
            dap_w_t w_reg;
            logic [2:0] wleft_reg;
            logic [2:0] wleft_next;
            logic [`DAP_ID_W-1:0] wid_reg;
            logic cmd_rdy_reg;
            logic wd_rdy_reg;
            logic ar_fire;
            logic aw_fire;
            logic w_fire;
            logic cmd_take;
            logic rd_take;
            logic wr_take;
            logic wd_take;

            // Port 1 is only offered requests when the integrator enables it
            assign port_on = (p == 0) | second_port_enable;

            // Bus transfers complete only on enabled edges
            assign ar_fire = ar_v_reg & m_arready[p] & bus_domain_clock_enable;
            assign aw_fire = aw_v_reg & m_awready[p] & bus_domain_clock_enable;
            assign w_fire = w_v_reg & m_wready[p] & bus_domain_clock_enable;
            assign cmd_take = cmd_valid[p] & cmd_rdy_reg;
            assign rd_take = cmd_take & ~cmd[p].write;
            assign wr_take = cmd_take & cmd[p].write;
            assign wd_take = wd_valid[p] & wd_rdy_reg;

            // Next occupancy of each outgoing stage
            always_comb begin
                ar_v_next = rd_take | (ar_v_reg & ~ar_fire);
                aw_v_next = wr_take | (aw_v_reg & ~aw_fire);
                w_v_next = wd_take | (w_v_reg & ~w_fire);
                wleft_next = wleft_reg;
                if (wr_take) begin
                    wleft_next = 3'(clamp_len(cmd[p].len)) + 3'h1;
                end else if (wd_take) begin
                    wleft_next = wleft_reg - 3'h1;
                end
            end

            // Stage valids and beat count
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ar_v_reg <= 1'b0;
                    aw_v_reg <= 1'b0;
                    w_v_reg <= 1'b0;
                    wleft_reg <= 3'h0;
                end else begin
                    ar_v_reg <= ar_v_next;
                    aw_v_reg <= aw_v_next;
                    w_v_reg <= w_v_next;
                    wleft_reg <= wleft_next;
                end
            end

            // Registered readies; one idle cycle per request keeps them honest
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmd_rdy_reg <= 1'b0;
                    wd_rdy_reg <= 1'b0;
                end else begin
                    cmd_rdy_reg <= port_on & ~ar_v_next & ~aw_v_next & ~w_v_next
                                   & (wleft_next == 3'h0);
                    wd_rdy_reg <= (wleft_next != 3'h0) & ~w_v_next;
                end
            end

            // Address payloads load only into an empty stage
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ar_reg <= '0;
                    aw_reg <= '0;
                    wid_reg <= '0;
                end else begin
                    if (rd_take) begin
                        ar_reg <= to_ar(cmd[p]);
                    end
                    if (wr_take) begin
                        aw_reg <= to_aw(cmd[p]);
                        wid_reg <= cmd[p].id;
                    end
                end
            end

            // Write beats take the burst identifier and flag the final beat
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    w_reg <= '0;
                end else if (wd_take) begin
                    w_reg.id <= wid_reg;
                    w_reg.data <= wd[p].data;
                    w_reg.strb <= wd[p].strb;
                    w_reg.last <= (wleft_reg == 3'h1);
                end
            end

            assign m_arvalid[p] = ar_v_reg;
            assign m_ar[p] = ar_reg;
            assign m_awvalid[p] = aw_v_reg;
            assign m_aw[p] = aw_reg;
            assign m_wvalid[p] = w_v_reg;
            assign m_w[p] = w_reg;
            assign cmd_ready[p] = cmd_rdy_reg;
            assign wd_ready[p] = wd_rdy_reg;

            // Read data return stage
            dap_sink_slot #(
                .W($bits(dap_r_t))
            ) u_rslot (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .bus_en(bus_domain_clock_enable),
                .in_valid(m_rvalid[p]),
                .in_data(m_r[p]),
                .in_ready(m_rready[p]),
                .out_valid(rd_valid[p]),
                .out_data(rd[p]),
                .out_ready(rd_ready[p])
            );

            // Write response return stage
            dap_sink_slot #(
                .W($bits(dap_b_t))
            ) u_bslot (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .bus_en(bus_domain_clock_enable),
                .in_valid(m_bvalid[p]),
                .in_data(m_b[p]),
                .in_ready(m_bready[p]),
                .out_valid(rsp_valid[p]),
                .out_data(rsp[p]),
                .out_ready(rsp_ready[p])
            );
        end
    endgenerate

endmodule : dap_top
